// ### bench/dma_engine_assertions.sv
/*
  Port timing checker for the transfer engine.
  Bound to dma_engine; sees only its top-level ports.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_engine_assertions (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Handshake
  input wire logic bus_hold_request_o,
  input wire logic bus_hold_grant_i,
  input wire logic [3:0] channel_ack_o,
  input wire logic ready_i,
  input wire logic end_of_process_oe_o,
  // Transfer bus
  input wire logic addr_enable_out_o,
  input wire logic upper_addr_latch_strobe_o,
  input wire logic [7:0] addr_o,
  input wire logic addr_oe_o,
  input wire logic mem_read_strobe_n_o,
  input wire logic mem_write_strobe_n_o,
  input wire logic io_read_strobe_n_o,
  input wire logic io_write_strobe_n_o,
  input wire logic strobe_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========
  // Properties
  strb_excl_a: assert property (
    !(!mem_read_strobe_n_o && !mem_write_strobe_n_o) && !(!io_read_strobe_n_o && !io_write_strobe_n_o))
    else $error("strobes clash");
  float_idle_a: assert property (
    !strobe_oe_o |-> !addr_enable_out_o && !upper_addr_latch_strobe_o && !addr_oe_o)
    else $error("enables while float");
  grant_first_a: assert property (
    !bus_hold_grant_i |=> !upper_addr_latch_strobe_o)
    else $error("address without grant");
  hrq_wait_a: assert property (
    bus_hold_request_o && !bus_hold_grant_i && !addr_enable_out_o |=> bus_hold_request_o)
    else $error("request dropped early");
  idle_gap_a: assert property (
    $fell(bus_hold_request_o) |=> !bus_hold_request_o)
    else $error("no idle gap");
  upper_addr_latch_strobe_pulse_a: assert property (
    upper_addr_latch_strobe_o |=> !upper_addr_latch_strobe_o && addr_enable_out_o)
    else $error("address strobe too long");
  wait_hold_a: assert property (
    (!mem_write_strobe_n_o || !io_write_strobe_n_o) && !ready_i
      |=> $stable(addr_o) && $stable({mem_write_strobe_n_o, io_write_strobe_n_o}))
    else $error("wait state moved bus");
  eop_pulse_a: assert property (
    end_of_process_oe_o |=> !end_of_process_oe_o)
    else $error("end pulse too long");
  ack_gate_a: assert property (
    $onehot0(~channel_ack_o) && (bus_hold_grant_i || &channel_ack_o))
    else $error("stray acknowledge");
endmodule : dma_engine_assertions

bind dma_engine dma_engine_assertions dma_engine_assertions_i (
  .clk_sys_i, .arst_n_i, .bus_hold_request_o, .bus_hold_grant_i, .channel_ack_o, .ready_i,
  .end_of_process_oe_o, .addr_enable_out_o, .upper_addr_latch_strobe_o, .addr_o, .addr_oe_o,
  .mem_read_strobe_n_o, .mem_write_strobe_n_o, .io_read_strobe_n_o, .io_write_strobe_n_o, .strobe_oe_o
);
`default_nettype wire

// ### bench/dma_engine_tb.sv
/*
  Self-checking bench for the transfer engine.
  Assumes the host model file and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_engine_tb
  import dma_pkg::*;
;
  logic clk_sys_i, arst_n_i, reg_cs_n_i, reg_rd_i, reg_wr_i, ready_i, grant, slow, rd_d, rnd_rdy, rdy_lvl;
  logic [3:0] reg_addr_i, channel_request_i, channel_ack_o, prv, pack;
  logic [7:0] reg_wdata_i, reg_rdata_o, data_i, cbyte;
  logic bus_hold_request_o, eop_oe, mr, mw, ir, iw;
  int n_fail, checks, seed, tmp, r, cyc;
  int cnt [4];
  logic [7:0] expq [$];
  int acks [$];
  dma_engine dma_engine_i (
    .clk_sys_i, .arst_n_i, .reg_cs_n_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .bus_hold_request_o, .bus_hold_grant_i(grant), .channel_request_i, .channel_ack_o, .ready_i,
    .end_of_process_n_i(!eop_oe), .end_of_process_oe_o(eop_oe), .addr_enable_out_o(),
    .upper_addr_latch_strobe_o(), .addr_o(), .addr_oe_o(), .data_i, .data_o(), .data_oe_o(),
    .mem_read_strobe_n_o(mr), .mem_write_strobe_n_o(mw), .io_read_strobe_n_o(ir), .io_write_strobe_n_o(iw),
    .strobe_oe_o()
  );
  dma_host_model dma_host_model_i (
    .clk_sys_i, .arst_n_i, .bus_hold_request_i(bus_hold_request_o),
    .slow_i(slow), .bus_hold_grant_o(grant)
  );
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // ==========
  // Monitors
  always @(negedge clk_sys_i)
  begin
    prv &= ~{iw, ir, mw, mr};
    for (int i = 0; i < 4; i++)
      if (prv[i]) cnt[i]++;
    if (&pack && !(&channel_ack_o))
      for (int i = 0; i < 4; i++)
        if (!channel_ack_o[i]) acks.push_back(i);
    prv = {iw, ir, mw, mr};
    pack = channel_ack_o;
    if (rd_d) check("reg_rdata_o", {8'h00, reg_rdata_o}, {8'h00, expq.pop_front()});
  end
  always @(posedge clk_sys_i)
  begin
    rd_d <= reg_rd_i && !reg_cs_n_i;
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      give_verdict();
    end
    #1;
    tmp = $random(seed);
    ready_i = rnd_rdy ? tmp[0] : rdy_lvl;
    data_i = rnd_rdy ? tmp[15:8] : cbyte;
  end
  // ==========
  // Tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    {reg_cs_n_i, reg_wr_i, reg_rd_i} = {1'b0, w, !w};
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_sys_i);
    #1;
    {reg_cs_n_i, reg_wr_i, reg_rd_i} = 3'b100;
    @(posedge clk_sys_i);
    #1;
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a, e[15:8]);
  endtask : rd16
  task automatic prog(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] n, input logic [5:0] md);
    acc(1'b1, OFS_CLR_FF, 8'h00);
    for (int b = 0; b < 4; b++)
      acc(1'b1, {1'b0, ch, b[1]}, 8'({n, a} >> (8 * b)));
    acc(1'b1, OFS_MODE, {md, ch});
    cnt = '{default: 0};
    acks.delete();
  endtask : prog
  task automatic wait_quiet();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 20; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      q = (bus_hold_request_o || grant) ? 0 : q + 1;
    end
    check("bus quiet", 16'(q), 16'(20));
  endtask : wait_quiet
  task automatic serve(input logic [3:0] req, input int ch);
    channel_request_i = req;
    for (int i = 0; i < 200 && channel_ack_o[ch] !== 1'b0; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    check("ack", {15'h0, channel_ack_o[ch]}, 16'h0000);
    channel_request_i = 4'h0;
  endtask : serve
  function automatic logic [15:0] pulses();
    return {cnt[3][3:0], cnt[2][3:0], cnt[1][3:0], cnt[0][3:0]};
  endfunction : pulses
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ==========
  // Sequence
  initial
  begin
    seed = 32'h5EEECC8C;
    {arst_n_i, reg_rd_i, reg_wr_i, slow, rnd_rdy, rd_d} = '0;
    {reg_cs_n_i, rdy_lvl, ready_i} = '1;
    {reg_addr_i, channel_request_i, reg_wdata_i, data_i, cbyte} = '0;
    {prv, pack} = 8'hFF;
    repeat (10) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    rd16(4'h6, 16'h0000);
    prog(2'd0, 16'h1234, 16'h0005, 6'h00);
    rd16(4'h0, 16'h1234);
    rd(4'h9, 8'h00);
    $display("Test registers done");
    rnd_rdy = 1'b1;
    prog(2'd1, 16'h2000, 16'h0001, {SEL_SINGLE, 2'b00, TYPE_READ});
    acc(1'b1, OFS_CLR_MASK, 8'h00);
    channel_request_i = 4'h2;
    wait_quiet();
    check("read pulses", pulses(), 16'h2002);
    check("hrq masked", {15'h0, bus_hold_request_o}, 16'h0000);
    rd(OFS_STATUS, 8'h22);
    rd16(4'h2, 16'h2002);
    rd16(4'h3, 16'hFFFF);
    channel_request_i = 4'h0;
    $display("Test read single done");
    slow = 1'b1;
    acc(1'b1, OFS_CMD, 8'h08);
    prog(2'd2, 16'h0101, 16'h0002, {SEL_BLOCK, 2'b10, TYPE_WRITE});
    acc(1'b1, OFS_CLR_MASK, 8'h00);
    serve(4'h4, 2);
    wait_quiet();
    check("write pulses", pulses(), 16'h0330);
    rd(OFS_STATUS, 8'h04);
    rd16(4'h4, 16'h00FE);
    $display("Test write block done");
    {rnd_rdy, rdy_lvl} = 2'b00;
    acc(1'b1, OFS_CMD, 8'h00);
    prog(2'd3, 16'h0040, 16'h0001, {SEL_BLOCK, 2'b01, TYPE_VERIFY});
    acc(1'b1, OFS_CLR_MASK, 8'h00);
    serve(4'h8, 3);
    wait_quiet();
    check("verify pulses", pulses(), 16'h0000);
    rd16(4'h6, 16'h0040);
    rd16(4'h7, 16'h0001);
    serve(4'h8, 3);
    wait_quiet();
    $display("Test verify done");
    r = $random(seed);
    cbyte = r[7:0];
    rdy_lvl = 1'b1;
    prog(2'd1, 16'h0020, 16'h0000, {SEL_BLOCK, 2'b00, TYPE_VERIFY});
    prog(2'd0, 16'h0010, 16'h0000, {SEL_BLOCK, 2'b00, TYPE_WRITE});
    acc(1'b1, OFS_MASK_ALL, 8'h0F);
    acc(1'b1, OFS_CMD, 8'h09);
    acc(1'b1, OFS_REQ, 8'h04);
    wait_quiet();
    check("copy pulses", pulses(), 16'h0011);
    check("copy acks", 16'(acks.size()), 16'h0000);
    rd(OFS_TEMP, cbyte);
    rd16(4'h2, 16'h0021);
    $display("Test copy done");
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, OFS_CMD, k ? 8'h30 : 8'h00);
      for (int c = 0; c < 4; c++)
        prog(c[1:0], 16'h0300, 16'h0010, {(k ? SEL_DEMAND : SEL_SINGLE), 2'b00, TYPE_READ});
      acc(1'b1, OFS_CLR_MASK, 8'h00);
      serve(4'h2, 1);
      wait_quiet();
      acks.delete();
      serve(4'h9, k ? 3 : 0);
      wait_quiet();
      check("first ack", 16'(acks[0]), k ? 16'h0003 : 16'h0000);
    end
    $display("Test priority done");
    give_verdict();
  end
endmodule : dma_engine_tb
`default_nettype wire

// ### bench/dma_host_model.sv
/*
  Host processor model granting the bus on a hold request.
  Assumes the engine's clock; slow_i stretches the grant delay.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_host_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Hold handshake
  input wire logic bus_hold_request_i,
  input wire logic slow_i,
  output logic bus_hold_grant_o
);
  int cnt;
  assign bus_hold_grant_o = cnt > (slow_i ? 4 : 1);
  always @(posedge clk_sys_i or negedge arst_n_i)
    cnt <= (!arst_n_i || !bus_hold_request_i) ? 0 : cnt + 1;
endmodule : dma_host_model
`default_nettype wire

// ### rtl/dma_engine.sv
/*
  Four-channel transfer engine: priority, hold handshake, transfer
  sequencing and per-channel address and count registers.
  Assumes all inputs synchronous to clk_sys_i; two-way pins are
  resolved outside from the enables.
*/
// Behaviour
// [R1] Read type pulses memory read and io write low, others high.
// [R2] Write type pulses memory write and io read low, others high.
// [R3] Verify keeps strobes driven high, ignores ready, outputs address.
// [R4] Memory copy alternates channel 0 source and channel 1 destination.
// [R5] Each copied byte is a four-state read then four-state write.
// [R6] Memory copy ignores the transfer type of channels 0 and 1.
// [R7] Copy starts by software request 0; acks idle, address enable high.
// [R8] Host sets equal counts, block mode and all masks before copy.
// [R9] Command bit 4 low gives fixed priority, channel 0 highest.
// [R10] Command bit 4 high rotates; serviced channel becomes lowest.
// [R11] Single mode moves one word per grant, then one idle state.
// [R12] Block mode runs to terminal count despite request dropping.
// [R13] Terminal count on count wrap or end-of-process before strobes.
// [R14] Address state skipped when upper address byte is unchanged.
// [R15] Demand mode runs while request active, resumes later.
// [R16] Cascade grant asserts only ack; bus pins float, enables low.
// [R17] End-of-process never ends a cascade operation.
// [R18] Auto-initialise reloads current registers from base at terminal count.
// [R19] Terminal count sets the mask bit unless auto-initialising.
// [R20] Extended write starts write strobe in the read strobe state.
// [R21] Compressed timing drops write state; ignored for memory copy.
// [R22] 16-bit current address steps per word; writes also load base.
// [R23] Wait in request state until grant; grant one clock after request; the host model grants two clocks after, five with slow_i.
// [R24] Read strobe in strobe state, write in write state; final updates.
// [R25] Ready low inserts wait states holding strobes and address.
// [R26] Requests active high, acks active low after reset; invertible.
`timescale 1ns/100ps
`default_nettype none
module dma_engine
  import dma_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Host register port
  input wire logic reg_cs_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Hold handshake
  output logic bus_hold_request_o,
  input wire logic bus_hold_grant_i,
  // Channel handshake
  input wire logic [3:0] channel_request_i,
  output logic [3:0] channel_ack_o,
  input wire logic ready_i,
  input wire logic end_of_process_n_i,
  output logic end_of_process_oe_o,
  // Transfer bus
  output logic addr_enable_out_o,
  output logic upper_addr_latch_strobe_o,
  output logic [7:0] addr_o,
  output logic addr_oe_o,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic mem_read_strobe_n_o,
  output logic mem_write_strobe_n_o,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic strobe_oe_o
);
  typedef struct packed {
    dma_state_t st;
    logic [3:0][15:0] cur_addr;
    logic [3:0][15:0] base_addr;
    logic [3:0][15:0] cur_cnt;
    logic [3:0][15:0] base_cnt;
    logic [3:0][5:0] mode;
    logic [7:0] cmd;
    logic [3:0] mask;
    logic [3:0] sw_req;
    logic [3:0] tc_stat;
    logic [7:0] temp;
    logic ff;
    logic [1:0] chan;
    logic [1:0] last;
    logic mm;
    logic mm_wr;
    logic eop_seen;
    logic eop_oe;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic [7:0] rdata;
    logic bus_hold_request;
    logic addr_enable_out;
    logic upper_addr_latch_strobe;
    logic [3:0] ack;
    logic [7:0] addr;
    logic addr_oe;
    logic [7:0] dbo;
    logic db_oe;
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic ior_n;
    logic iow_n;
    logic strobe_oe;
  } dma_core_t;

  dma_core_t s;
  dma_core_t n;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [3:0] channel_request_act;
  logic [3:0] pend;
  logic [2:0] pk;
  logic [1:0] c;
  logic [1:0] tys;
  logic [1:0] ty;
  logic [15:0] ca;
  logic eop_now;
  logic tcev;
  logic hold;
  logic acc;
  logic act;
  logic rd_on;
  logic wr_on;

  dma_fifo_if #(.W(8)) fq ();

  dma_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .f(fq.fifo_side)
  );

  assign fq.in_valid = s.push;
  assign fq.in_data = s.push_data;
  assign fq.out_ready = s.pop;

  // ==========
  // Helpers
  function automatic logic [2:0] dma_pick(input logic [3:0] p, input logic [1:0] lo);
    logic [2:0] r;
    logic [1:0] k;
    r = 3'h0;
    for (int i = 4; i >= 1; i--)
    begin
      k = lo + 2'(i);
      if (p[k])
        r = {1'b1, k};
    end
    return r;
  endfunction : dma_pick

  function automatic logic [15:0] dma_step(input logic [15:0] a, input logic dec);
    return dec ? a - 16'h0001 : a + 16'h0001;
  endfunction : dma_step

  function automatic logic [15:0] dma_put(input logic [15:0] w, input logic hi, input logic [7:0] b);
    return hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : dma_put

  // ==========
  // Reset release
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ==========
  // Next state
  always_comb
  begin
    n = s;
    n.eop_oe = 1'b0;
    n.push = 1'b0;
    n.pop = 1'b0;
    // [R26] Request polarity
    channel_request_act = channel_request_i ^ {4{s.cmd[CMD_REQ_LOW]}};
    pend = (channel_request_act & ~s.mask) | s.sw_req;
    // [R9] [R10] Priority pick
    pk = dma_pick(pend, s.cmd[CMD_ROTATE] ? s.last : RST_LAST);
    c = s.chan;
    tys = s.mode[c][MD_TYPE_LSB +: 2];
    eop_now = !end_of_process_n_i && !s.eop_oe;
    tcev = 1'b0;
    // [R3] [R25] Wait states, not for verify
    hold = !ready_i && (s.mm || tys != TYPE_VERIFY);
    acc = !reg_cs_n_i && !bus_hold_grant_i;

    // Host access
    if (acc && reg_wr_i)
    begin
      if (!reg_addr_i[3])
      begin
        n.ff = !s.ff;
        // [R22] Address write loads base too
        if (!reg_addr_i[0])
        begin
          n.cur_addr[reg_addr_i[2:1]] = dma_put(s.cur_addr[reg_addr_i[2:1]], s.ff, reg_wdata_i);
          n.base_addr[reg_addr_i[2:1]] = dma_put(s.cur_addr[reg_addr_i[2:1]], s.ff, reg_wdata_i);
        end
        else
        begin
          n.cur_cnt[reg_addr_i[2:1]] = dma_put(s.cur_cnt[reg_addr_i[2:1]], s.ff, reg_wdata_i);
          n.base_cnt[reg_addr_i[2:1]] = dma_put(s.cur_cnt[reg_addr_i[2:1]], s.ff, reg_wdata_i);
        end
      end
      else
      begin
        unique case (reg_addr_i)
          OFS_CMD: n.cmd = reg_wdata_i;
          OFS_REQ: n.sw_req[reg_wdata_i[1:0]] = reg_wdata_i[2];
          OFS_MASK_ONE: n.mask[reg_wdata_i[1:0]] = reg_wdata_i[2];
          OFS_MODE: n.mode[reg_wdata_i[1:0]] = reg_wdata_i[7:2];
          OFS_CLR_FF: n.ff = 1'b0;
          OFS_MASTER_CLR:
          begin
            n.mask = RST_MASK;
            n.cmd = RST_CMD;
            n.temp = 8'h00;
            n.tc_stat = 4'h0;
            n.ff = 1'b0;
            n.sw_req = 4'h0;
          end
          OFS_CLR_MASK: n.mask = 4'h0;
          OFS_MASK_ALL: n.mask = reg_wdata_i[3:0];
          default: n.ff = s.ff;
        endcase
      end
    end
    else if (acc && reg_rd_i)
    begin
      if (!reg_addr_i[3])
      begin
        n.ff = !s.ff;
        ca = reg_addr_i[0] ? s.cur_cnt[reg_addr_i[2:1]] : s.cur_addr[reg_addr_i[2:1]];
        n.rdata = s.ff ? ca[15:8] : ca[7:0];
      end
      else if (reg_addr_i == OFS_STATUS)
      begin
        n.rdata = {channel_request_act, s.tc_stat};
        n.tc_stat = 4'h0;
      end
      else if (reg_addr_i == OFS_TEMP)
        n.rdata = s.temp;
      else
        n.rdata = 8'h00;
    end

    // Sequencer
    unique case (s.st)
      ST_IDLE:
      begin
        n.eop_seen = 1'b0;
        n.mm = 1'b0;
        n.mm_wr = 1'b0;
        // [R11] Request only while grant is low
        if (!s.cmd[CMD_DISABLE] && !bus_hold_grant_i)
        begin
          // [R7] Copy starts from software request 0
          if (s.cmd[CMD_MEM2MEM] && s.sw_req[0])
          begin
            n.mm = 1'b1;
            n.chan = 2'h0;
            n.st = ST_HOLD;
          end
          else if (pk[2])
          begin
            n.chan = pk[1:0];
            n.st = ST_HOLD;
          end
        end
      end
      ST_HOLD:
      begin
        n.eop_seen = s.eop_seen || eop_now;
        // [R23] Wait for grant
        if (bus_hold_grant_i)
        begin
          // [R16] Cascade only acknowledges
          if (!s.mm && s.mode[c][MD_SEL_LSB +: 2] == SEL_CASCADE)
            n.st = ST_CASC;
          else
            n.st = ST_ADDR;
        end
      end
      ST_CASC:
      begin
        // [R17] End-of-process ignored here
        if (!channel_request_act[c])
        begin
          n.last = c;
          n.st = ST_IDLE;
        end
      end
      ST_ADDR:
      begin
        n.eop_seen = s.eop_seen || eop_now;
        // [R4] Destination byte from buffer
        if (s.mm && s.mm_wr)
        begin
          if (fq.out_valid)
          begin
            n.temp = fq.out_data;
            n.pop = 1'b1;
            n.st = ST_READ;
          end
        end
        else
          n.st = ST_READ;
      end
      ST_READ:
      begin
        // [R21] Compressed skips write state
        if (s.cmd[CMD_COMPRESS] && !s.mm)
        begin
          if (!hold)
            n.st = ST_FINAL;
        end
        else
          n.st = ST_WRITE;
      end
      ST_WRITE:
      begin
        // [R4] [R25] Copy byte taken while read strobe low; hold if not ready
        n.push = s.mm && !s.mm_wr && !hold && fq.in_ready;
        n.push_data = data_i;
        if (!hold && !(s.mm && !s.mm_wr && !fq.in_ready))
          n.st = ST_FINAL;
      end
      ST_FINAL:
      begin
        // [R24] Update address and count
        n.cur_addr[c] = dma_step(s.cur_addr[c], s.mode[c][MD_DEC]);
        n.cur_cnt[c] = s.cur_cnt[c] - 16'h0001;
        // [R13] Terminal count
        tcev = (s.cur_cnt[c] == 16'h0000) || s.eop_seen;
        n.eop_seen = eop_now;
        if (s.mm && !s.mm_wr)
        begin
          // [R4] [R5] Source done; destination phase next
          n.mm_wr = 1'b1;
          n.chan = 2'h1;
          n.eop_seen = s.eop_seen || eop_now;
          n.st = ST_ADDR;
        end
        else if (tcev)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (i == int'(c) || (s.mm && i == 0))
            begin
              n.tc_stat[i] = 1'b1;
              // [R18] Auto-initialise reload
              if (s.mode[i][MD_AUTO])
              begin
                n.cur_addr[i] = s.base_addr[i];
                n.cur_cnt[i] = s.base_cnt[i];
              end
              // [R19] Mask after terminal count
              else
                n.mask[i] = 1'b1;
            end
          end
          n.eop_oe = !s.eop_seen;
          n.sw_req = 4'h0;
          n.last = c;
          n.st = ST_IDLE;
        end
        // [R11] [R15] Single ends; demand ends on drop
        else if (!s.mm && (s.mode[c][MD_SEL_LSB +: 2] == SEL_SINGLE ||
                 (s.mode[c][MD_SEL_LSB +: 2] == SEL_DEMAND && !channel_request_act[c])))
        begin
          n.sw_req = 4'h0;
          n.last = c;
          n.st = ST_IDLE;
        end
        else if (s.mm)
        begin
          // [R4] Back to the source
          n.mm_wr = 1'b0;
          n.chan = 2'h0;
          n.st = ST_ADDR;
        end
        // [R12] [R14] Continue, skipping unchanged upper byte
        else if (n.cur_addr[c][15:8] == s.cur_addr[c][15:8])
          n.st = ST_READ;
        else
          n.st = ST_ADDR;
      end
      default: n.st = ST_IDLE;
    endcase

    // Pin values for the state being entered
    ca = n.cur_addr[n.chan];
    ty = n.mode[n.chan][MD_TYPE_LSB +: 2];
    act = (n.st == ST_ADDR) || (n.st == ST_READ) || (n.st == ST_WRITE) || (n.st == ST_FINAL);
    rd_on = (n.st == ST_READ) || (n.st == ST_WRITE);
    // [R20] [R21] Early write strobe
    wr_on = (n.st == ST_WRITE) || ((n.st == ST_READ) &&
            (n.cmd[CMD_EXT_WRITE] || (n.cmd[CMD_COMPRESS] && !n.mm)));
    n.bus_hold_request = (n.st != ST_IDLE);
    // [R7] Address enable during transfers
    n.addr_enable_out = act;
    n.upper_addr_latch_strobe = (n.st == ST_ADDR);
    n.addr = ca[7:0];
    n.addr_oe = act;
    n.db_oe = (n.st == ST_ADDR) || (n.mm && n.mm_wr && rd_on);
    n.dbo = (n.st == ST_ADDR) ? ca[15:8] : n.temp;
    n.strobe_oe = act;
    // [R1] [R2] [R6] Strobes by type or copy phase
    n.mem_read_strobe_n = !(rd_on && (n.mm ? !n.mm_wr : ty == TYPE_READ));
    n.iow_n = !(wr_on && !n.mm && ty == TYPE_READ);
    n.mem_write_strobe_n = !(wr_on && (n.mm ? n.mm_wr : ty == TYPE_WRITE));
    n.ior_n = !(rd_on && !n.mm && ty == TYPE_WRITE);
    // [R7] [R16] [R26] Acknowledge with polarity
    for (int i = 0; i < 4; i++)
    begin
      n.ack[i] = (((act && !n.mm) || n.st == ST_CASC) && i == int'(n.chan)) ^ !n.cmd[CMD_ACK_HIGH];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cur_addr <= {4{RST_WORD}};
      s.base_addr <= {4{RST_WORD}};
      s.cur_cnt <= {4{RST_WORD}};
      s.base_cnt <= {4{RST_WORD}};
      s.mode <= {4{RST_MODE}};
      s.cmd <= RST_CMD;
      s.mask <= RST_MASK;
      s.last <= RST_LAST;
      s.ack <= 4'hF;
      s.mem_read_strobe_n <= 1'b1;
      s.mem_write_strobe_n <= 1'b1;
      s.ior_n <= 1'b1;
      s.iow_n <= 1'b1;
    end
    else
      s <= n;
  end

  // ==========
  // Outputs
  assign reg_rdata_o = s.rdata;
  assign bus_hold_request_o = s.bus_hold_request;
  assign channel_ack_o = s.ack;
  assign end_of_process_oe_o = s.eop_oe;
  assign addr_enable_out_o = s.addr_enable_out;
  assign upper_addr_latch_strobe_o = s.upper_addr_latch_strobe;
  assign addr_o = s.addr;
  assign addr_oe_o = s.addr_oe;
  assign data_o = s.dbo;
  assign data_oe_o = s.db_oe;
  assign mem_read_strobe_n_o = s.mem_read_strobe_n;
  assign mem_write_strobe_n_o = s.mem_write_strobe_n;
  assign io_read_strobe_n_o = s.ior_n;
  assign io_write_strobe_n_o = s.iow_n;
  assign strobe_oe_o = s.strobe_oe;
endmodule : dma_engine
`default_nettype wire

// ### rtl/dma_fifo.sv
/*
  Synchronous FIFO, width and depth as parameters.
  Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_fifo
  import dma_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dma_fifo_if.fifo_side f
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } dma_fifo_state_t;

  dma_fifo_state_t s;
  dma_fifo_state_t next_s;
  logic [W-1:0] mem [D];
  logic do_push;
  logic do_pop;

  assign f.in_ready = (s.cnt != CW'(D));
  assign f.out_valid = (s.cnt != '0);
  assign f.out_data = mem[s.rp];

  always_comb
  begin
    do_push = f.in_valid && f.in_ready;
    do_pop = f.out_valid && f.out_ready;
    next_s = s;
    if (do_push)
    begin
      next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
    end
    if (do_pop)
    begin
      next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (do_push)
      mem[s.wp] <= f.in_data;
  end
endmodule : dma_fifo
`default_nettype wire

// ### rtl/dma_fifo_if.sv
/*
  Valid/ready carrier between the engine and its data buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface dma_fifo_if #(parameter int W = 8) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : dma_fifo_if
`default_nettype wire

// ### rtl/dma_pkg.sv
/*
  Constants and types shared by the four-channel transfer engine.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package dma_pkg;
  // ==========
  // Register offsets on reg_addr_i
  localparam logic [3:0] OFS_CMD = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_REQ = 4'h9;
  localparam logic [3:0] OFS_MASK_ONE = 4'hA;
  localparam logic [3:0] OFS_MODE = 4'hB;
  localparam logic [3:0] OFS_CLR_FF = 4'hC;
  localparam logic [3:0] OFS_MASTER_CLR = 4'hD;
  localparam logic [3:0] OFS_TEMP = 4'hD;
  localparam logic [3:0] OFS_CLR_MASK = 4'hE;
  localparam logic [3:0] OFS_MASK_ALL = 4'hF;
  // ==========
  // Command bit positions
  localparam int CMD_MEM2MEM = 0;
  localparam int CMD_DISABLE = 2;
  localparam int CMD_COMPRESS = 3;
  localparam int CMD_ROTATE = 4;
  localparam int CMD_EXT_WRITE = 5;
  localparam int CMD_REQ_LOW = 6;
  localparam int CMD_ACK_HIGH = 7;
  // ==========
  // Mode field positions (6 stored bits)
  localparam int MD_TYPE_LSB = 0;
  localparam int MD_AUTO = 2;
  localparam int MD_DEC = 3;
  localparam int MD_SEL_LSB = 4;
  localparam logic [1:0] TYPE_VERIFY = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_READ = 2'h2;
  localparam logic [1:0] SEL_DEMAND = 2'h0;
  localparam logic [1:0] SEL_SINGLE = 2'h1;
  localparam logic [1:0] SEL_BLOCK = 2'h2;
  localparam logic [1:0] SEL_CASCADE = 2'h3;
  // ==========
  // Reset values
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [3:0] RST_MASK = 4'hF;
  localparam logic [1:0] RST_LAST = 2'h3;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_MODE = 6'h00;
  // ==========
  // Engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_HOLD = 7'h02,
    ST_ADDR = 7'h04,
    ST_READ = 7'h08,
    ST_WRITE = 7'h10,
    ST_FINAL = 7'h20,
    ST_CASC = 7'h40
  } dma_state_t;
endpackage : dma_pkg
`default_nettype wire
